//--- i2cs_assertions.sv
// i2cs_assertions: checks on the shared two-wire bus lines.
// assumes: tb instantiates it once beside the interface.
`timescale 1ns/1ps
`default_nettype none
module i2cs_assertions (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic h_scl_oe,
  input wire logic t_sda_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence scl_hi2; scl && $past(scl); endsequence
  sequence tgt_pull; $rose(t_sda_oe); endsequence
  sequence bus_stop; $rose(sda) and scl_hi2; endsequence
  // run length of one target pull; address ack plus a zero byte is 9 bits
  logic [7:0] run;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !t_sda_oe) begin
      run <= 8'h00;
    end else if (run != 8'hFF) begin
      run <= run + 8'h01;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  scl_owner_a: assert property (!scl |-> h_scl_oe)
    else $error("scl low while controller released it");
  tgt_still_a: assert property (scl_hi2 |-> $stable(t_sda_oe))
    else $error("target moved sda while scl high");
  pull_low_a: assert property (tgt_pull |-> !scl)
    else $error("target pulled sda outside scl low");
  free_low_a: assert property ($fell(t_sda_oe) |-> !scl)
    else $error("target released sda outside scl low");
  ack_hold_a: assert property (tgt_pull |-> t_sda_oe [*8])
    else $error("target pull shorter than a bit");
  start_free_a: assert property (($fell(sda) and scl_hi2) |-> !t_sda_oe)
    else $error("start made by target");
  stop_idle_a: assert property (bus_stop |-> !t_sda_oe [*8])
    else $error("target drives after stop");
  tgt_bound_a: assert property (run <= 8'h9C)
    else $error("target held sda too long");
endmodule : i2cs_assertions
`default_nettype wire

//--- i2cs_ctrl.sv
// i2cs_ctrl: bus controller end; makes scl from clk_i by a divider and runs
// one write or subaddress-then-read transaction per command.
// assumes: a single target on the bus; len_i of at least one byte.
`timescale 1ns/1ps
`default_nettype none
module i2cs_ctrl
  import i2cs_pkg::*;
#(
  parameter int CLK_HZ = I2CS_CLK_HZ,
  parameter int SCL_HZ = I2CS_FAST_HZ
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  i2cs_if.ctrl            bus,
  input  wire logic       cmd_valid_i,
  output logic            cmd_ready_o,
  input  wire logic       cmd_rw_i,
  input  wire logic [7:0] cmd_sub_i,
  input  wire logic [7:0] cmd_len_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  input  wire logic [7:0] tx_data_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            done_o,
  output logic            nack_o
);

  // ----------------------------------------------------------------------
  // timing: one bit slot is four quarters, scl low in the first two
  // ----------------------------------------------------------------------
  localparam int         QTR      = CLK_HZ / (4 * SCL_HZ);
  localparam logic [7:0] QTR_LAST = 8'(QTR - 1);

  typedef struct packed {
    logic            rq;
    logic            sda_s1;
    logic            sda_s2;
    logic [7:0]      qc;
    logic [1:0]      q;
    logic            smp;
    i2cs_ctl_state_t state;
    i2cs_phase_t     ph;
    logic            pend;
    logic            got;
    logic [7:0]      sh;
    logic [2:0]      cnt;
    logic            rw;
    logic [7:0]      sub;
    logic [7:0]      left;
    logic            scl_oe;
    logic            sda_oe;
    logic            drv0;
    logic            cmd_ready;
    logic            tx_ready;
    logic            rx_valid;
    logic [7:0]      rx_data;
    logic            done;
    logic            nack;
  } i2cs_ctl_t;

  i2cs_ctl_t s;
  i2cs_ctl_t next_s;

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    logic tick;
    tick            = (s.qc == QTR_LAST);
    next_s          = s;
    next_s.sda_s1   = bus.sda;
    next_s.sda_s2   = s.sda_s1;
    next_s.qc       = tick ? '0 : s.qc + 8'h01;
    next_s.rx_valid = 1'b0;
    next_s.done     = 1'b0;
    if (tick) begin
      next_s.q = s.q + 2'h1;
    end
    if (cmd_valid_i && s.cmd_ready) begin
      next_s.cmd_ready = 1'b0;
      next_s.pend      = 1'b1;
      next_s.rw        = cmd_rw_i;
      next_s.sub       = cmd_sub_i;
      next_s.left      = cmd_len_i;
    end
    if (tx_valid_i && s.tx_ready) begin
      next_s.tx_ready = 1'b0;
      next_s.got      = 1'b1;
      next_s.sh       = tx_data_i;
    end
    // data moves a quarter after scl falls, start/stop mid-high
    if (tick && s.q == I2CS_Q_DRIVE) begin
      unique case (s.state)
        C_TX:    next_s.sda_oe = ~s.sh[7];
        C_RXACK: next_s.sda_oe = (s.left != 8'h01);
        C_STOP:  next_s.sda_oe = 1'b1;
        default: next_s.sda_oe = 1'b0;
      endcase
    end
    if (tick && s.q == I2CS_Q_SAMPLE) begin
      next_s.smp = s.sda_s2;
      if (s.state == C_START) begin
        next_s.sda_oe = 1'b1;
      end
      if (s.state == C_STOP) begin
        next_s.sda_oe = 1'b0;
      end
    end
    if (tick && s.q == I2CS_Q_LAST) begin
      unique case (s.state)
        C_IDLE: begin
          if (s.pend) begin
            next_s.pend  = 1'b0;
            next_s.ph    = P_AW;
            next_s.state = C_START;
          end
        end
        C_START: begin
          next_s.sh    = {I2CS_DEV_ADDR, (s.ph == P_AR) ? I2CS_RW_RD : I2CS_RW_WR};
          next_s.cnt   = '0;
          next_s.state = C_TX;
        end
        C_TX: begin
          next_s.sh  = {s.sh[6:0], 1'b0};
          next_s.cnt = s.cnt + 3'h1;
          if (s.cnt == I2CS_LAST_BIT) begin
            next_s.state = C_TXACK;
          end
        end
        C_TXACK: begin
          next_s.cnt = '0;
          if (s.smp == I2CS_NACK) begin
            next_s.nack  = 1'b1;
            next_s.state = C_STOP;
          end else begin
            unique case (s.ph)
              P_AW: begin
                next_s.ph    = P_SUB;
                next_s.sh    = s.sub;
                next_s.state = C_TX;
              end
              P_SUB: begin
                next_s.ph       = (s.rw == I2CS_RW_RD) ? P_AR : P_WD;
                next_s.state    = (s.rw == I2CS_RW_RD) ? C_START : C_WAITD;
                next_s.tx_ready = (s.rw == I2CS_RW_WR);
              end
              P_AR: begin
                next_s.ph    = P_RD;
                next_s.state = C_RX;
              end
              default: begin
                next_s.left     = s.left - 8'h01;
                next_s.state    = (s.left == 8'h01) ? C_STOP : C_WAITD;
                next_s.tx_ready = (s.left != 8'h01);
              end
            endcase
          end
        end
        C_WAITD: begin
          if (s.got) begin
            next_s.got   = 1'b0;
            next_s.state = C_TX;
          end
        end
        C_RX: begin
          next_s.sh  = {s.sh[6:0], s.smp};
          next_s.cnt = s.cnt + 3'h1;
          if (s.cnt == I2CS_LAST_BIT) begin
            next_s.rx_valid = 1'b1;
            next_s.rx_data  = {s.sh[6:0], s.smp};
            next_s.state    = C_RXACK;
          end
        end
        C_RXACK: begin
          next_s.cnt   = '0;
          next_s.left  = s.left - 8'h01;
          next_s.state = (s.left == 8'h01) ? C_STOP : C_RX;
        end
        C_STOP: begin
          next_s.state     = C_IDLE;
          next_s.done      = 1'b1;
          next_s.cmd_ready = 1'b1;
        end
      endcase
    end
    // scl held low while waiting for data, high when idle
    if (tick) begin
      next_s.scl_oe = (next_s.state == C_WAITD) ||
                      ((next_s.state != C_IDLE) && (next_s.q < I2CS_Q_HIGH));
    end
    if (!rst_n_i) begin
      // divider keeps clocking with sda released so the target's link
      // domain sees edges and takes its reset; the first reset edge clears
      // it, since counting on from power-up garbage never settles
      next_s           = '0;
      next_s.rq        = 1'b1;
      if (s.rq) begin
        next_s.qc     = tick ? '0 : s.qc + 8'h01;
        next_s.q      = tick ? s.q + 2'h1 : s.q;
        next_s.scl_oe = tick ? (next_s.q < I2CS_Q_HIGH) : s.scl_oe;
      end
      next_s.cmd_ready = 1'b0;
    end else if (s.state == C_IDLE && !s.pend && !s.cmd_ready && !tick) begin
      next_s.cmd_ready = !s.scl_oe;
    end
  end

  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  assign bus.h_scl_o  = s.drv0;
  assign bus.h_scl_oe = s.scl_oe;
  assign bus.h_sda_o  = s.drv0;
  assign bus.h_sda_oe = s.sda_oe;
  assign cmd_ready_o  = s.cmd_ready;
  assign tx_ready_o   = s.tx_ready;
  assign rx_valid_o   = s.rx_valid;
  assign rx_data_o    = s.rx_data;
  assign done_o       = s.done;
  assign nack_o       = s.nack;

endmodule : i2cs_ctrl
`default_nettype wire

//--- i2cs_if.sv
// i2cs_if: the two-wire bus between controller and target, resolved as a
// wired-AND with pullups.
// assumes: the bench connects one controller and one target to it.
`timescale 1ns/1ps
`default_nettype none
interface i2cs_if;
  logic h_scl_o;
  logic h_scl_oe;
  logic h_sda_o;
  logic h_sda_oe;
  logic t_sda_o;
  logic t_sda_oe;
  logic scl;
  logic sda;

  // a driver pulls low only while enabled and driving zero
  assign scl = !(h_scl_oe && !h_scl_o);
  assign sda = !((h_sda_oe && !h_sda_o) || (t_sda_oe && !t_sda_o));

  modport ctrl   (input scl, input sda, output h_scl_o, output h_scl_oe,
                  output h_sda_o, output h_sda_oe);
  modport target (input scl, input sda, output t_sda_o, output t_sda_oe);
endinterface : i2cs_if
`default_nettype wire

//--- i2cs_pkg.sv
// i2cs_pkg: constants, state types and decode helpers shared by both ends of
// the serial control port.
// assumes: nothing beyond a SystemVerilog compiler.
`default_nettype none
package i2cs_pkg;

  // ----------------------------------------------------------------------
  // bus constants
  // ----------------------------------------------------------------------
  localparam logic [6:0] I2CS_DEV_ADDR    = 7'h36;
  localparam logic [7:0] I2CS_WIDE_BASE   = 8'h20;  // first word-wide subaddress
  localparam logic [1:0] I2CS_NARROW_LAST = 2'h0;   // last byte index, 1-byte location
  localparam logic [1:0] I2CS_WIDE_LAST   = 2'h3;   // last byte index, 4-byte location
  localparam logic [2:0] I2CS_LAST_BIT    = 3'h7;
  localparam logic       I2CS_ACK         = 1'b0;
  localparam logic       I2CS_NACK        = 1'b1;
  localparam logic       I2CS_RW_WR       = 1'b0;
  localparam logic       I2CS_RW_RD       = 1'b1;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int         I2CS_CLK_HZ      = 40_000_000;
  localparam int         I2CS_STD_HZ      = 100_000;
  localparam int         I2CS_FAST_HZ     = 400_000;
  localparam logic [1:0] I2CS_Q_DRIVE     = 2'h0;   // leaving this quarter: data moves
  localparam logic [1:0] I2CS_Q_SAMPLE    = 2'h2;   // leaving this quarter: sample
  localparam logic [1:0] I2CS_Q_LAST      = 2'h3;
  localparam logic [1:0] I2CS_Q_HIGH      = 2'h2;   // quarters at or above are scl high

  // ----------------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    T_IDLE, T_ADDR, T_ADDR_ACK, T_SUB, T_SUB_ACK, T_WDATA, T_WDATA_ACK, T_RDATA, T_RDATA_ACK
  } i2cs_tgt_state_t;

  typedef enum logic [2:0] {
    C_IDLE, C_START, C_TX, C_TXACK, C_WAITD, C_RX, C_RXACK, C_STOP
  } i2cs_ctl_state_t;

  typedef enum logic [2:0] {P_AW, P_SUB, P_WD, P_AR, P_RD} i2cs_phase_t;

  // ----------------------------------------------------------------------
  // location decode
  // ----------------------------------------------------------------------
  function automatic logic [1:0] i2cs_last_idx(input logic [7:0] sub);
    return (sub < I2CS_WIDE_BASE) ? I2CS_NARROW_LAST : I2CS_WIDE_LAST;
  endfunction : i2cs_last_idx

  // byte idx of a location, most significant byte first
  function automatic logic [7:0] i2cs_byte_of(input logic [31:0] word,
                                               input logic [7:0]  sub,
                                               input logic [1:0]  idx);
    logic [4:0] ofs;
    ofs = {~idx, 3'h0};
    return (sub < I2CS_WIDE_BASE) ? word[7:0] : word[ofs +: 8];
  endfunction : i2cs_byte_of

endpackage : i2cs_pkg
`default_nettype wire

//--- i2cs_target.sv
// i2cs_target: slave end of the control port of the audio_processing_core.
// assumes: scl is the link clock and only toggles with a live controller;
// a user store answers rd_addr_o combinationally on rd_data_i.
//
// Overview of operation
// - works at 100 kHz and 400 kHz
// - slave only, never stretches scl
// - bytes are eight bits, msb first
// - ack holds sda low whole ninth clock
// - sda fall/rise with scl high: start/stop
// - sda changes only while scl low
// - answers only fixed address 0x36
// - no cap on bytes per transfer
// - low subaddresses bytewide, upper ones word-sets
// - reads stream on, unused bits read zero
// - incomplete set at stop/restart is dropped
// - sequential write advances subaddress per set
// - only the trailing partial set is dropped
// - write: address, subaddress, data, all acked
// - read: subaddress write, restart, read address
// - controller nacks last read byte, stops
// - address byte acked before anything else
`timescale 1ns/1ps
`default_nettype none
module i2cs_target
  import i2cs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  i2cs_if.target           bus,
  output logic             wr_valid_o,
  output logic [7:0]       wr_addr_o,
  output logic [31:0]      wr_data_o,
  output logic [7:0]       rd_addr_o,
  input  wire logic [31:0] rd_data_i,
  output logic             busy_o
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic            rst_s1;
    logic            rst_s2;
    logic            st_s1;
    logic            st_s2;
    logic            st_seen;
    logic            prv;
    i2cs_tgt_state_t state;
    logic [7:0]      sh;
    logic [2:0]      cnt;
    logic            rw;
    logic [7:0]      sub;
    logic [1:0]      bidx;
    logic [31:0]     wbuf;
    logic [31:0]     cur;
    logic            wr_tgl;
    logic [7:0]      wr_addr;
    logic [31:0]     wr_data;
    logic            fe_tgl;
    logic [7:0]      fe_addr;
    logic            sdo;
    logic            oe;
  } i2cs_lnk_t;

  typedef struct packed {
    logic        scl_s1;
    logic        scl_s2;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_q;
    logic        start_tgl;
    logic        busy;
    logic        wr_s1;
    logic        wr_s2;
    logic        wr_q;
    logic        wr_valid;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic        fe_s1;
    logic        fe_s2;
    logic        fe_q;
    logic        cap;
    logic [7:0]  rd_addr;
    logic [31:0] rd_word;
  } i2cs_sys_t;

  i2cs_lnk_t l;
  i2cs_lnk_t next_l;
  i2cs_sys_t c;
  i2cs_sys_t next_c;
  logic      smp;

  // ----------------------------------------------------------------------
  // link side: sample on rising scl, act and drive on falling scl
  // ----------------------------------------------------------------------
  // sda is stable while scl is high, so the rising edge is the safe sample
  always_ff @(posedge bus.scl) begin
    smp <= bus.sda;
  end

  always_comb begin
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic [7:0] nsub;
    logic [1:0] nbidx;
    logic       newloc;
    rx_byte  = {l.sh[6:0], smp};
    tx_byte  = '0;
    nsub     = l.sub;
    nbidx    = l.bidx + 2'h1;
    newloc   = 1'b0;
    next_l   = l;
    next_l.rst_s1 = rst_n_i;
    next_l.rst_s2 = l.rst_s1;
    next_l.st_s1  = c.start_tgl;
    next_l.st_s2  = l.st_s1;
    next_l.prv    = smp;
    if (!l.rst_s2) begin
      next_l         = '0;
      next_l.rst_s1  = rst_n_i;
      next_l.rst_s2  = l.rst_s1;
      next_l.st_s1   = c.start_tgl;
      next_l.st_s2   = l.st_s1;
      next_l.st_seen = l.st_s2;
      next_l.prv     = smp;
    end else if (l.st_s2 != l.st_seen) begin
      // start is seen two falling edges late: the address msb waits in prv
      // and the next bit in smp; any partial set is abandoned here
      next_l.st_seen = l.st_s2;
      next_l.state   = T_ADDR;
      next_l.sh      = {6'h00, l.prv, smp};
      next_l.cnt     = 3'h2;
      next_l.bidx    = '0;
      next_l.wbuf    = '0;
      next_l.oe      = 1'b0;
    end else begin
      unique case (l.state)
        T_IDLE: begin
          next_l.oe = 1'b0;
        end
        T_ADDR: begin
          next_l.sh  = rx_byte;
          next_l.cnt = l.cnt + 3'h1;
          if (l.cnt == I2CS_LAST_BIT) begin
            if (rx_byte[7:1] == I2CS_DEV_ADDR) begin
              next_l.rw    = rx_byte[0];
              next_l.state = T_ADDR_ACK;
              next_l.oe    = 1'b1;
            end else begin
              next_l.state = T_IDLE;
            end
          end
        end
        T_ADDR_ACK: begin
          next_l.cnt = '0;
          if (l.rw == I2CS_RW_RD) begin
            tx_byte        = i2cs_byte_of(c.rd_word, l.sub, l.bidx);
            next_l.cur     = c.rd_word;
            next_l.sh      = tx_byte;
            next_l.oe      = ~tx_byte[7];
            next_l.fe_tgl  = ~l.fe_tgl;
            next_l.fe_addr = l.sub + 8'h01;
            next_l.state   = T_RDATA;
          end else begin
            next_l.oe    = 1'b0;
            next_l.state = T_SUB;
          end
        end
        T_SUB: begin
          next_l.sh  = rx_byte;
          next_l.cnt = l.cnt + 3'h1;
          if (l.cnt == I2CS_LAST_BIT) begin
            next_l.sub     = rx_byte;
            next_l.fe_tgl  = ~l.fe_tgl;
            next_l.fe_addr = rx_byte;
            next_l.bidx    = '0;
            next_l.wbuf    = '0;
            next_l.state   = T_SUB_ACK;
            next_l.oe      = 1'b1;
          end
        end
        T_SUB_ACK: begin
          next_l.oe    = 1'b0;
          next_l.cnt   = '0;
          next_l.state = T_WDATA;
        end
        T_WDATA: begin
          next_l.sh  = rx_byte;
          next_l.cnt = l.cnt + 3'h1;
          if (l.cnt == I2CS_LAST_BIT) begin
            next_l.oe    = 1'b1;
            next_l.state = T_WDATA_ACK;
            next_l.wbuf  = {l.wbuf[23:0], rx_byte};
            next_l.bidx  = nbidx;
            if (l.bidx == i2cs_last_idx(l.sub)) begin
              // only complete sets reach the store
              next_l.wr_tgl  = ~l.wr_tgl;
              next_l.wr_addr = l.sub;
              next_l.wr_data = {l.wbuf[23:0], rx_byte};
              next_l.sub     = l.sub + 8'h01;
              next_l.fe_tgl  = ~l.fe_tgl;
              next_l.fe_addr = l.sub + 8'h01;
              next_l.bidx    = '0;
              next_l.wbuf    = '0;
            end
          end
        end
        T_WDATA_ACK: begin
          next_l.oe    = 1'b0;
          next_l.cnt   = '0;
          next_l.state = T_WDATA;
        end
        T_RDATA: begin
          next_l.cnt = l.cnt + 3'h1;
          if (l.cnt == I2CS_LAST_BIT) begin
            next_l.oe    = 1'b0;
            next_l.state = T_RDATA_ACK;
          end else begin
            next_l.sh = {l.sh[6:0], 1'b0};
            next_l.oe = ~l.sh[6];
          end
        end
        T_RDATA_ACK: begin
          if (l.bidx == i2cs_last_idx(l.sub)) begin
            nsub   = l.sub + 8'h01;
            nbidx  = '0;
            newloc = 1'b1;
          end
          next_l.sub  = nsub;
          next_l.bidx = nbidx;
          next_l.cnt  = '0;
          if (smp == I2CS_ACK) begin
            // the prefetched word is for nsub; fetch the one after it
            tx_byte = i2cs_byte_of(newloc ? c.rd_word : l.cur, nsub, nbidx);
            if (newloc) begin
              next_l.cur     = c.rd_word;
              next_l.fe_tgl  = ~l.fe_tgl;
              next_l.fe_addr = nsub + 8'h01;
            end
            next_l.sh    = tx_byte;
            next_l.oe    = ~tx_byte[7];
            next_l.state = T_RDATA;
          end else begin
            // a later read starts location nsub from its first byte
            next_l.oe      = 1'b0;
            next_l.bidx    = '0;
            next_l.fe_tgl  = ~l.fe_tgl;
            next_l.fe_addr = nsub;
            next_l.state   = T_IDLE;
          end
        end
      endcase
    end
  end

  // sda moves only on falling scl; scl is never driven here
  always_ff @(negedge bus.scl) begin
    l <= next_l;
  end

  assign bus.t_sda_o  = l.sdo;
  assign bus.t_sda_oe = l.oe;

  // ----------------------------------------------------------------------
  // system side: start/stop watch, write hand-off, read fetch
  // ----------------------------------------------------------------------
  // the link holds wr_* and fe_addr for many scl periods after each
  // toggle, so the words are stable by the time the toggle is seen here
  always_comb begin
    next_c          = c;
    next_c.scl_s1   = bus.scl;
    next_c.scl_s2   = c.scl_s1;
    next_c.sda_s1   = bus.sda;
    next_c.sda_s2   = c.sda_s1;
    next_c.sda_q    = c.sda_s2;
    next_c.wr_s1    = l.wr_tgl;
    next_c.wr_s2    = c.wr_s1;
    next_c.wr_q     = c.wr_s2;
    next_c.fe_s1    = l.fe_tgl;
    next_c.fe_s2    = c.fe_s1;
    next_c.fe_q     = c.fe_s2;
    next_c.wr_valid = 1'b0;
    next_c.cap      = 1'b0;
    if (c.scl_s2 && c.sda_q && !c.sda_s2) begin
      next_c.start_tgl = ~c.start_tgl;
      next_c.busy      = 1'b1;
    end
    if (c.scl_s2 && !c.sda_q && c.sda_s2) begin
      next_c.busy = 1'b0;
    end
    if (c.wr_s2 != c.wr_q) begin
      next_c.wr_valid = 1'b1;
      next_c.wr_addr  = l.wr_addr;
      next_c.wr_data  = l.wr_data;
    end
    if (c.fe_s2 != c.fe_q) begin
      next_c.rd_addr = l.fe_addr;
      next_c.cap     = 1'b1;
    end
    if (c.cap) begin
      next_c.rd_word = rd_data_i;
    end
    if (!rst_n_i) begin
      next_c = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    c <= next_c;
  end

  assign wr_valid_o = c.wr_valid;
  assign wr_addr_o  = c.wr_addr;
  assign wr_data_o  = c.wr_data;
  assign rd_addr_o  = c.rd_addr;
  assign busy_o     = c.busy;

endmodule : i2cs_target
`default_nettype wire

//--- tb.sv
// tb: controller and target face each other; random transfers checked.
// assumes: the design files and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import i2cs_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cmd_v = 1'b0;
  logic        cmd_rw = 1'b0;
  logic [7:0]  cmd_sub = 8'h00;
  logic [7:0]  cmd_len = 8'h01;
  logic        tx_v = 1'b0;
  logic [7:0]  tx_d = 8'h00;
  logic        rdy, tx_rdy, rx_v, done, nack, wv, busy;
  logic [7:0]  rx_d, wa, ra;
  logic [31:0] wd, rd;
  logic [2:0]  hs;
  logic [15:0] seed = 16'hFEE9;
  logic [39:0] wq[$];
  logic [7:0]  rq[$];
  int          miscompares = 0;
  int          check_count = 0;
  always #12.5 clk_i = ~clk_i;
  assign hs = {done, tx_rdy, rdy};
  assign rd = mem(ra);
  always @(posedge clk_i) begin
    if (wv) wq.push_back({wa, wd});
    if (rx_v) rq.push_back(rx_d);
  end
  i2cs_if bus_if ();
  // short quarter (4 clocks) keeps reset and transfers brief
  i2cs_ctrl #(.CLK_HZ(40_000_000), .SCL_HZ(2_500_000)) u_i2cs_ctrl (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_if), .cmd_valid_i(cmd_v),
    .cmd_ready_o(rdy), .cmd_rw_i(cmd_rw), .cmd_sub_i(cmd_sub), .cmd_len_i(cmd_len),
    .tx_valid_i(tx_v), .tx_ready_o(tx_rdy), .tx_data_i(tx_d), .rx_valid_o(rx_v),
    .rx_data_o(rx_d), .done_o(done), .nack_o(nack));
  i2cs_target u_i2cs_target (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_if), .wr_valid_o(wv), .wr_addr_o(wa),
    .wr_data_o(wd), .rd_addr_o(ra), .rd_data_i(rd), .busy_o(busy));
  i2cs_assertions u_i2cs_assertions (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .scl(bus_if.scl), .sda(bus_if.sda),
    .h_scl_oe(bus_if.h_scl_oe), .t_sda_oe(bus_if.t_sda_oe));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  // store contents; unused upper bits of narrow places are zero
  function automatic logic [31:0] mem(input logic [7:0] a);
    return (a < 8'h20) ? {24'h0, a ^ 8'h5A} : {a, ~a, a ^ 8'h33, 8'hC3};
  endfunction : mem
  // walk the locations a read passes, so a wrap past 8'hFF is followed
  function automatic logic [7:0] exp_b(input logic [7:0] s, input int n);
    logic [31:0] w;
    logic [7:0]  a;
    int          k;
    a = s;
    k = 0;
    for (int j = 0; j < n; j++) begin
      if (a < 8'h20 || k == 3) begin
        a = a + 8'h01;
        k = 0;
      end else begin
        k++;
      end
    end
    w = mem(a);
    return (a < 8'h20) ? w[7:0] : w[31 - 8 * k -: 8];
  endfunction : exp_b
  task automatic close_out();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wt(input int k);
    int i;
    for (i = 0; i < 20000 && hs[k] !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (i == 20000) begin
      miscompares++;
      close_out();
    end
  endtask : wt
  // ----------------------------------------------------------------
  // one transfer with its checks
  // ----------------------------------------------------------------
  task automatic xfer(input logic rw, input logic [7:0] s, input int len);
    int i;
    int n;
    logic [7:0] b[$];
    logic [31:0] w;
    wq.delete();
    rq.delete();
    wt(0);
    cmd_v = 1'b1;
    cmd_rw = rw;
    cmd_sub = s;
    cmd_len = len[7:0];
    @(posedge clk_i);
    #1 cmd_v = 1'b0;
    for (i = 0; i < len && !rw; i++) begin
      seed = lfsr(seed);
      b.push_back(seed[7:0]);
      wt(1);
      chk(32'(busy), 32'h1);
      tx_v = 1'b1;
      tx_d = seed[7:0];
      @(posedge clk_i);
      #1 tx_v = 1'b0;
      @(posedge clk_i);
      #1;
    end
    wt(2);
    chk(32'(busy), 32'h0);
    n = (s < 8'h20) ? len : len / 4;
    chk(32'(rw ? rq.size() : wq.size()), 32'(rw ? len : n));
    for (i = 0; i < n && !rw; i++) begin
      w = (s < 8'h20) ? {24'h0, b[i]} : {b[4*i], b[4*i+1], b[4*i+2], b[4*i+3]};
      chk(32'(wq[i][39:32]), 32'(s + i[7:0]));
      chk(wq[i][31:0], w);
    end
    for (i = 0; i < len && rw; i++) chk(32'(rq[i]), 32'(exp_b(s, i)));
    chk(32'(nack), 32'h0);
  endtask : xfer
  initial begin
    repeat (60) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    xfer(1'b0, {4'h0, seed[11:8]}, 1);
    xfer(1'b0, {4'h1, seed[3:0]}, 3);
    xfer(1'b0, {2'h1, seed[13:8]}, 8);
    xfer(1'b0, {2'h2, seed[5:0]}, 6);
    xfer(1'b0, 8'h20, 3);
    xfer(1'b1, {4'h0, seed[7:4]}, 3);
    xfer(1'b1, {2'h3, seed[9:4]}, 5);
    close_out();
  end
endmodule : tb
`default_nettype wire
